/* verilog/ppc_pkg.sv */
package ppc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the plain register port
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_CTRL = 4'h2;
  localparam logic [3:0] OFF_DIRSEL = 4'h3;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFF_IRQ_EN = 4'h5;
  localparam logic [3:0] OFF_IRQ_CLR = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // printer_control / printer_command_readback bit positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_AFEED = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_IRQEN = 4;
  localparam int CTL_DIR = 5;

  // reset and fixed values
  localparam logic [7:0] CTRL_RST = 8'hC0;
  localparam logic [2:0] CMD_UNUSED = 3'h7;
  localparam logic [1:0] STAT_UNUSED = 2'h3;
  localparam logic [7:0] DIRSEL_RST = 8'h00;
  localparam logic [7:0] DIR_OUT_CODE = 8'h55;
  localparam logic [7:0] DIR_IN_CODE = 8'hAA;
  localparam logic [7:0] DATA_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events
  localparam int NUM_EV = 4;
  localparam int EV_ACK = 0;
  localparam int EV_BUSY = 1;
  localparam int EV_ERR = 2;
  localparam int EV_PE = 3;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser vector layout and idle levels
  localparam int SYNC_W = 18;
  localparam int SY_DATA = 0;
  localparam int SY_STB = 8;
  localparam int SY_AFD = 9;
  localparam int SY_INIT = 10;
  localparam int SY_SEL = 11;
  localparam int SY_ACK = 12;
  localparam int SY_ERR = 13;
  localparam int SY_SLCT = 14;
  localparam int SY_PE = 15;
  localparam int SY_BUSY = 16;
  localparam int SY_BIDIR_ENABLE_INPUT = 17;
  localparam logic [17:0] SYNC_RST = 18'h13B00;

endpackage

/* verilog/ppc_port.sv */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Function
// R1: control bit 0 set pulls strobe low; software returns it high, no auto pulse.
// R2: control bit 1 set pulls auto-feed low; reset value 0.
// R3: control bit 2 drives initialize pin with same polarity; reset value 0.
// R4: control bit 3 set pulls select-in low; reset value 0.
// R5: control bit 4 enables printer interrupt output; 0 masks it; reset masks.
// R6: with bidir enable high, control bit 5: 0 data outputs, 1 inputs.
// R7: command register reads back control settings except the direction bit.
// R8: command bit 3 reads select-in pin inverted.
// R9: command bit 4 reads printer interrupt enable.
// R10: command bits 5 to 7 always read 1.
// R11: four handshake lines are open-drain with pull-up, wire-OR capable.
// R12: reset clears control bits 0 to 5; bits 6 and 7 read 1.
// R13: after reset command bits 0 to 4 read 0, bits 5 to 7 read 1.
// R14: status bits 0 and 1 read 1; bits 2 to 7 follow inputs.
// R15: with bidir enable low, 0x55 to direction select gives outputs, 0xAA inputs.
// R16: data write latches onto data pins when outputs; pins released when inputs.
// R17: software releases a handshake driver before reading that line as input.
module ppc_port
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // data pins
  input wire logic [7:0] printer_data_pins_i,
  output logic [7:0] printer_data_pins_o,
  output logic printer_data_pins_oe,
  // open-drain handshake lines
  input wire logic strobe_n_i,
  output logic strobe_n_o,
  output logic strobe_n_oe,
  input wire logic auto_feed_n_i,
  output logic auto_feed_n_o,
  output logic auto_feed_n_oe,
  input wire logic init_i,
  output logic init_o,
  output logic init_oe,
  input wire logic select_in_n_i,
  output logic select_in_n_o,
  output logic select_in_n_oe,
  // printer status inputs
  input wire logic ack_n,
  input wire logic error_n,
  input wire logic select_fb,
  input wire logic paper_end,
  input wire logic busy,
  input wire logic bidir_enable_input,
  // interrupts
  output logic printer_irq_out,
  output logic irq
);

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: stage one feeds stage two only
  logic [17:0] sync1_ff;
  logic [17:0] sync2_ff;
  logic [17:0] prev_ff;
  logic [17:0] async_in;

  assign async_in = {bidir_enable_input, busy, paper_end, select_fb, error_n, ack_n,
                     select_in_n_i, init_i, auto_feed_n_i, strobe_n_i,
                     printer_data_pins_i};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_ff <= ppc_pkg::SYNC_RST;
      sync2_ff <= ppc_pkg::SYNC_RST;
      prev_ff <= ppc_pkg::SYNC_RST;
    end
    else
    begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  logic bidir_enable_input_s;
  assign bidir_enable_input_s = sync2_ff[ppc_pkg::SY_BIDIR_ENABLE_INPUT];

  ////////////////////////////////////////////////////////////////////////////
  // printer_control register
  logic [7:0] ctrl_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_ff <= ppc_pkg::CTRL_RST; // see R12
    else if (wr && hit(addr, ppc_pkg::OFF_CTRL))
      ctrl_ff <= {2'h3, wdata[5:0]}; // unused bits stay 1, see R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction select and data latch
  logic [7:0] dirsel_ff;
  logic dirsel_in_ff;
  logic [7:0] data_ff;
  logic dir_in;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dirsel_ff <= ppc_pkg::DIRSEL_RST;
      dirsel_in_ff <= 1'b0;
    end
    else if (wr && hit(addr, ppc_pkg::OFF_DIRSEL))
    begin
      dirsel_ff <= wdata;
      // other patterns are stored but leave the direction alone
      if (wdata == ppc_pkg::DIR_OUT_CODE)
        dirsel_in_ff <= 1'b0; // see R15
      else if (wdata == ppc_pkg::DIR_IN_CODE)
        dirsel_in_ff <= 1'b1; // see R15
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      data_ff <= ppc_pkg::DATA_RST;
    else if (wr && hit(addr, ppc_pkg::OFF_DATA))
      data_ff <= wdata; // see R16
  end

  // bidir enable picks which register owns the bus direction
  assign dir_in = bidir_enable_input_s ? ctrl_ff[ppc_pkg::CTL_DIR] : dirsel_in_ff; // see R6, R15
  assign printer_data_pins_o = data_ff;
  assign printer_data_pins_oe = !dir_in; // see R16

  ////////////////////////////////////////////////////////////////////////////
  // open-drain handshake drivers: only ever pull low, pull-up gives the high
  assign strobe_n_o = 1'b0;
  assign auto_feed_n_o = 1'b0;
  assign init_o = 1'b0;
  assign select_in_n_o = 1'b0;
  assign strobe_n_oe = ctrl_ff[ppc_pkg::CTL_STROBE]; // see R1, R11
  assign auto_feed_n_oe = ctrl_ff[ppc_pkg::CTL_AFEED]; // see R2, R11
  assign init_oe = !ctrl_ff[ppc_pkg::CTL_INIT]; // see R3, R11
  assign select_in_n_oe = ctrl_ff[ppc_pkg::CTL_SELIN]; // see R4, R11

  ////////////////////////////////////////////////////////////////////////////
  // readback values
  logic [7:0] cmd_val;
  logic [7:0] stat_val;
  logic [7:0] data_val;

  // lines read back from the pins so a far-side driver shows up; see R17
  assign cmd_val = {ppc_pkg::CMD_UNUSED, // see R10, R13
                    ctrl_ff[ppc_pkg::CTL_IRQEN], // see R7, R9
                    !sync2_ff[ppc_pkg::SY_SEL], // see R8
                    sync2_ff[ppc_pkg::SY_INIT],
                    !sync2_ff[ppc_pkg::SY_AFD],
                    !sync2_ff[ppc_pkg::SY_STB]}; // see R7

  // bit 2 is the pending flag, tracking the acknowledge line
  assign stat_val = {sync2_ff[ppc_pkg::SY_BUSY], sync2_ff[ppc_pkg::SY_ACK],
                     sync2_ff[ppc_pkg::SY_PE], sync2_ff[ppc_pkg::SY_SLCT],
                     sync2_ff[ppc_pkg::SY_ERR], sync2_ff[ppc_pkg::SY_ACK],
                     ppc_pkg::STAT_UNUSED}; // see R14

  assign data_val = dir_in ? sync2_ff[7:0] : data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events, sticky status, enable and clear
  logic [3:0] ev;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_en_ff;
  logic clr_wr;

  assign ev[ppc_pkg::EV_ACK] = prev_ff[ppc_pkg::SY_ACK] && !sync2_ff[ppc_pkg::SY_ACK];
  assign ev[ppc_pkg::EV_BUSY] = prev_ff[ppc_pkg::SY_BUSY] && !sync2_ff[ppc_pkg::SY_BUSY];
  assign ev[ppc_pkg::EV_ERR] = prev_ff[ppc_pkg::SY_ERR] && !sync2_ff[ppc_pkg::SY_ERR];
  assign ev[ppc_pkg::EV_PE] = !prev_ff[ppc_pkg::SY_PE] && sync2_ff[ppc_pkg::SY_PE];
  assign clr_wr = wr && hit(addr, ppc_pkg::OFF_IRQ_CLR);

  genvar gi;
  generate
    for (gi = 0; gi < ppc_pkg::NUM_EV; gi = gi + 1)
    begin : g_ev
      // a new event in the clear cycle survives the clear
      always_ff @(posedge clk)
      begin
        if (rst)
          irq_stat_ff[gi] <= 1'b0;
        else if (ev[gi])
          irq_stat_ff[gi] <= 1'b1;
        else if (clr_wr && wdata[gi])
          irq_stat_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_en_ff <= 4'h0;
    else if (wr && hit(addr, ppc_pkg::OFF_IRQ_EN))
      irq_en_ff <= wdata[3:0];
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // printer interrupt: acknowledge low, gated by control bit 4
  logic printer_irq_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
      printer_irq_ff <= 1'b0;
    else
      printer_irq_ff <= ctrl_ff[ppc_pkg::CTL_IRQEN] && !sync2_ff[ppc_pkg::SY_ACK]; // see R5
  end

  assign printer_irq_out = printer_irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read port: data valid only in the cycle after the strobe
  logic [7:0] rdata_ff;

  always_ff @(posedge clk)
  begin
    if (rst || !rd)
      rdata_ff <= 8'h00;
    else
    begin
      case (addr)
        ppc_pkg::OFF_DATA: rdata_ff <= data_val;
        ppc_pkg::OFF_STATUS: rdata_ff <= stat_val;
        ppc_pkg::OFF_CTRL: rdata_ff <= cmd_val; // see R7
        ppc_pkg::OFF_DIRSEL: rdata_ff <= dirsel_ff;
        ppc_pkg::OFF_IRQ_STAT: rdata_ff <= {4'h0, irq_stat_ff};
        ppc_pkg::OFF_IRQ_EN: rdata_ff <= {4'h0, irq_en_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_strobe_drive: // see R1
    assert property (wr && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> strobe_n_oe == $past(wdata[0]) && !strobe_n_o)
    else $error("strobe drive does not follow control bit 0");

  a_strobe_holds: // see R1
    assert property (strobe_n_oe && !(wr && hit(addr, ppc_pkg::OFF_CTRL))
                     |=> strobe_n_oe)
    else $error("strobe released without a control write");

  a_afeed_drive: // see R2
    assert property (wr && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> auto_feed_n_oe == $past(wdata[1]))
    else $error("auto feed drive does not follow control bit 1");

  a_init_drive: // see R3
    assert property (wr && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> init_oe == !$past(wdata[2]))
    else $error("init drive polarity wrong");

  a_selin_drive: // see R4
    assert property (wr && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> select_in_n_oe == $past(wdata[3]))
    else $error("select in drive does not follow control bit 3");

  a_irq_masked: // see R5
    assert property (!ctrl_ff[ppc_pkg::CTL_IRQEN] |=> !printer_irq_out)
    else $error("printer interrupt not masked");

  a_dir_bidir: // see R6
    assert property ((wr && hit(addr, ppc_pkg::OFF_CTRL) && bidir_enable_input_s) ##1 bidir_enable_input_s
                     |-> printer_data_pins_oe == !$past(wdata[5]))
    else $error("data direction does not follow control bit 5");

  a_cmd_read: // see R7
    assert property (rd && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> rdata[7:4] == {3'h7, $past(ctrl_ff[ppc_pkg::CTL_IRQEN])})
    else $error("command readback upper bits wrong");

  a_selin_read: // see R8
    assert property (rd && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> rdata[3] == !$past(sync2_ff[ppc_pkg::SY_SEL]))
    else $error("select in readback not inverted");

  a_ctrl_reset: // see R12
    assert property ($fell(rst) |-> ctrl_ff == ppc_pkg::CTRL_RST)
    else $error("control register reset value wrong");

  a_status_low: // see R14
    assert property (rd && hit(addr, ppc_pkg::OFF_STATUS) |=> rdata[1:0] == 2'h3)
    else $error("status unused bits not 1");

  a_dirsel_code: // see R15
    assert property ((wr && hit(addr, ppc_pkg::OFF_DIRSEL) && wdata == ppc_pkg::DIR_OUT_CODE)
                     ##1 !bidir_enable_input_s |-> printer_data_pins_oe)
    else $error("direction select output code did not give outputs");

  a_dirsel_input: // see R15
    assert property ((wr && hit(addr, ppc_pkg::OFF_DIRSEL) && wdata == ppc_pkg::DIR_IN_CODE)
                     ##1 !bidir_enable_input_s |-> !printer_data_pins_oe)
    else $error("direction select input code did not release the data pins");

  a_dirsel_keep: // see R15
    assert property (wr && hit(addr, ppc_pkg::OFF_DIRSEL) && wdata != ppc_pkg::DIR_OUT_CODE
                     && wdata != ppc_pkg::DIR_IN_CODE |=> dirsel_in_ff == $past(dirsel_in_ff))
    else $error("unknown direction pattern changed the direction");

  a_data_latch: // see R16
    assert property (wr && hit(addr, ppc_pkg::OFF_DATA)
                     |=> printer_data_pins_o == $past(wdata))
    else $error("data write not latched onto pins");

  a_rdata_once:
    assert property (!rd |=> rdata == 8'h00)
    else $error("read data stands beyond its cycle");

  a_event_sticky:
    assert property (ev[ppc_pkg::EV_ACK] |=> irq_stat_ff[ppc_pkg::EV_ACK])
    else $error("event lost against clear");

  a_clear_bit:
    assert property (clr_wr && wdata[ppc_pkg::EV_ACK] && !ev[ppc_pkg::EV_ACK]
                     |=> !irq_stat_ff[ppc_pkg::EV_ACK])
    else $error("acknowledge status not cleared");

  a_irq_follows: // see R5
    assert property (ctrl_ff[ppc_pkg::CTL_IRQEN] && !sync2_ff[ppc_pkg::SY_ACK]
                     |=> printer_irq_out)
    else $error("enabled printer interrupt did not follow acknowledge");

  a_init_read: // see R7
    assert property (rd && hit(addr, ppc_pkg::OFF_CTRL)
                     |=> rdata[2] == $past(sync2_ff[ppc_pkg::SY_INIT]))
    else $error("init readback wrong");

  a_cmd_reset: // see R13
    assert property ($fell(rst) |-> cmd_val == {ppc_pkg::CMD_UNUSED, 5'h00})
    else $error("command readback reset value wrong");

  a_status_read: // see R14
    assert property (rd && hit(addr, ppc_pkg::OFF_STATUS)
                     |=> rdata[7] == $past(sync2_ff[ppc_pkg::SY_BUSY])
                     && rdata[3] == $past(sync2_ff[ppc_pkg::SY_ERR]))
    else $error("status does not follow busy and error inputs");

  c_strobe_pulse:
    cover property (strobe_n_oe ##[1:20] !strobe_n_oe);
  c_dir_input:
    cover property (wr && hit(addr, ppc_pkg::OFF_DIRSEL) && wdata == 8'hAA);
  c_printer_irq:
    cover property (!printer_irq_out ##1 printer_irq_out);
  c_irq_clear_race:
    cover property (ev[ppc_pkg::EV_BUSY] && clr_wr && wdata[ppc_pkg::EV_BUSY]);
  c_dir_bidir_in:
    cover property (bidir_enable_input_s && ctrl_ff[ppc_pkg::CTL_DIR] && !printer_data_pins_oe);

endmodule // ppc_port

/* testbench/ppc_printer_model.sv */
`timescale 1ns/1ps
module ppc_printer_model
#(
  parameter int ACK_CYC = 6,
  parameter logic [7:0] REPLY = 8'h3C
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests from the bench
  input wire logic ack_req,
  input wire logic pull_sel_req,
  input wire logic host_data_oe,
  // printer side
  output logic ack_n,
  output logic busy,
  output logic [7:0] data_drv,
  output logic data_oe,
  output logic sel_pull
);
  logic [3:0] cnt_ff;

  // busy idles high and drops around the acknowledge pulse, so the host sees
  // busy fall before acknowledge and no false busy edge follows reset
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_ff <= 4'h0;
    else if (ack_req && cnt_ff == 4'h0)
      cnt_ff <= 4'(ACK_CYC + 2);
    else if (cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
  end

  assign busy = (cnt_ff == 4'h0);
  assign ack_n = !(cnt_ff > 4'h1 && cnt_ff <= 4'(ACK_CYC + 1));
  // never fights the host: drives data only once the host lets go
  assign data_oe = !host_data_oe;
  assign data_drv = REPLY;
  assign sel_pull = pull_sel_req;
endmodule // ppc_printer_model

/* testbench/printer_port_control_tb.sv */
`timescale 1ns/1ps
module printer_port_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, pd_o, pd_drv, pd_line;
  logic pd_oe, pd_drv_oe, ack_n, busy, prn_irq, irq, sel_pull;
  logic stb_o, stb_oe, afd_o, afd_oe, ini_o, ini_oe, sel_o, sel_oe;
  logic stb_line, afd_line, ini_line, sel_line;
  logic error_n = 1'b1;
  logic select_fb = 1'b0;
  logic paper_end = 1'b0;
  logic bidir = 1'b0;
  logic ack_req = 1'b0;
  logic pull_sel = 1'b0;
  logic [7:0] ctl_tab [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h3F, 8'h20, 8'h00};
  logic [7:0] dir_tab [3] = '{8'hAA, 8'h33, 8'h55};
  int miscompares = 0;
  int tests_run = 0;

  always #50 clk = ~clk;
  // open-drain lines: any enabled driver pulls low, else the pull-up wins
  assign stb_line = stb_oe ? stb_o : 1'b1;
  assign afd_line = afd_oe ? afd_o : 1'b1;
  assign ini_line = ini_oe ? ini_o : 1'b1;
  assign sel_line = (sel_oe ? sel_o : 1'b1) & !sel_pull;
  assign pd_line = pd_oe ? pd_o : (pd_drv_oe ? pd_drv : ~pd_o);

  ppc_port dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .printer_data_pins_i(pd_line), .printer_data_pins_o(pd_o),
    .printer_data_pins_oe(pd_oe), .strobe_n_i(stb_line), .strobe_n_o(stb_o),
    .strobe_n_oe(stb_oe), .auto_feed_n_i(afd_line), .auto_feed_n_o(afd_o),
    .auto_feed_n_oe(afd_oe), .init_i(ini_line), .init_o(ini_o), .init_oe(ini_oe),
    .select_in_n_i(sel_line), .select_in_n_o(sel_o), .select_in_n_oe(sel_oe),
    .ack_n(ack_n), .error_n(error_n), .select_fb(select_fb), .paper_end(paper_end),
    .busy(busy), .bidir_enable_input(bidir), .printer_irq_out(prn_irq), .irq(irq));

  ppc_printer_model model_u (.clk(clk), .rst(rst), .ack_req(ack_req),
    .pull_sel_req(pull_sel), .host_data_oe(pd_oe), .ack_n(ack_n), .busy(busy),
    .data_drv(pd_drv), .data_oe(pd_drv_oe), .sel_pull(sel_pull));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
  endtask

  // one acknowledge cycle, watching the printer interrupt in a bounded window
  task automatic ack_cycle(input logic want);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    ack_req <= 1'b1;
    @(posedge clk);
    ack_req <= 1'b0;
    repeat (12)
    begin
      @(negedge clk);
      seen |= (prn_irq === 1'b1);
    end
    chk1(seen, want);
    if (want && !seen)
      finish_test();
    cyc(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    chk({stb_line, afd_line, ini_line, sel_line, 3'h0, pd_oe}, 8'hD1);
    reg_rd(ppc_pkg::OFF_CTRL, 8'hE0);
    reg_rd(ppc_pkg::OFF_DIRSEL, 8'h00);
    reg_rd(ppc_pkg::OFF_STATUS, 8'hCF);
    reg_rd(4'h7, 8'h00);
    @(posedge clk);
    bidir <= 1'b1;
    foreach (ctl_tab[i])
    begin
      reg_wr(ppc_pkg::OFF_CTRL, ctl_tab[i]);
      cyc(5);
      chk({4'h0, stb_line, afd_line, ini_line, sel_line},
          {4'h0, ~ctl_tab[i][0], ~ctl_tab[i][1], ctl_tab[i][2], ~ctl_tab[i][3]});
      chk1(pd_oe, !ctl_tab[i][5]);
      reg_rd(ppc_pkg::OFF_CTRL, {3'h7, ctl_tab[i][4:0]});
    end
    @(posedge clk);
    bidir <= 1'b0;
    foreach (dir_tab[i])
    begin
      reg_wr(ppc_pkg::OFF_DIRSEL, dir_tab[i]);
      cyc(4);
      chk1(pd_oe, i == 2);
      reg_rd(ppc_pkg::OFF_DIRSEL, dir_tab[i]);
    end
    reg_wr(ppc_pkg::OFF_DATA, 8'hA5);
    cyc(1);
    chk(pd_line, 8'hA5);
    reg_rd(ppc_pkg::OFF_DATA, 8'hA5);
    reg_wr(ppc_pkg::OFF_DIRSEL, 8'hAA);
    cyc(4);
    chk1(pd_oe, 1'b0);
    reg_rd(ppc_pkg::OFF_DATA, 8'h3C);
    reg_wr(ppc_pkg::OFF_DIRSEL, 8'h55);
    // release the select-in driver before reading the line as an input
    reg_wr(ppc_pkg::OFF_CTRL, 8'h00);
    @(posedge clk);
    pull_sel <= 1'b1;
    cyc(4);
    reg_rd(ppc_pkg::OFF_CTRL, 8'hE8);
    reg_wr(ppc_pkg::OFF_CTRL, 8'h08);
    @(posedge clk);
    pull_sel <= 1'b0;
    cyc(4);
    reg_rd(ppc_pkg::OFF_CTRL, 8'hE8);
    reg_wr(ppc_pkg::OFF_CTRL, 8'h00);
    @(posedge clk);
    error_n <= 1'b0;
    paper_end <= 1'b1;
    select_fb <= 1'b1;
    cyc(6);
    reg_rd(ppc_pkg::OFF_STATUS, 8'hF7);
    reg_rd(ppc_pkg::OFF_IRQ_STAT, 8'h0C);
    chk1(irq, 1'b0);
    reg_wr(ppc_pkg::OFF_IRQ_EN, 8'h04);
    cyc(1);
    chk1(irq, 1'b1);
    reg_wr(ppc_pkg::OFF_IRQ_CLR, 8'h0C);
    cyc(1);
    chk1(irq, 1'b0);
    ack_cycle(1'b0);
    reg_rd(ppc_pkg::OFF_IRQ_STAT, 8'h03);
    reg_wr(ppc_pkg::OFF_IRQ_EN, 8'h01);
    cyc(1);
    chk1(irq, 1'b1);
    reg_wr(ppc_pkg::OFF_IRQ_CLR, 8'h01);
    cyc(1);
    chk1(irq, 1'b0);
    reg_rd(ppc_pkg::OFF_IRQ_STAT, 8'h02);
    reg_wr(ppc_pkg::OFF_CTRL, 8'h10);
    ack_cycle(1'b1);
    // strobe stays low until software returns it
    reg_wr(ppc_pkg::OFF_CTRL, 8'h11);
    cyc(20);
    chk1(stb_line, 1'b0);
    do_reset();
    chk({stb_line, afd_line, ini_line, sel_line, 3'h0, pd_oe}, 8'hD1);
    reg_rd(ppc_pkg::OFF_CTRL, 8'hE0);
    finish_test();
  end
endmodule // printer_port_control_tb
